// file: pkg/slp_pkg.sv
/*
 * speed-loop and speed-profile register slice: shared offsets, field layout and reset values
 * assumes an avalon-mm slave with 32-bit data and byte addressing
 */
// Contract
// RULE1: velocity proportional gain low seven bits live in bits 30..24 of the gain register.
// RULE2: proportional gain is 0.01 times low byte over ten to the top two bits.
// RULE3: ten-bit integral gain in bits 23..14; 0.1 times low byte over ten power.
// RULE4: fourteen-bit maximum speed in bits 13..0; electrical hertz equals value over six.
// RULE5: two-bit profile select in bits 30..29, reset zero: reference, linear, staircase, fwd-rev.
// RULE6: first turn-on duty threshold in bits 28..21, percent is value over 255.
// RULE7: first turn-off duty threshold in bits 20..13, same over-255 percent scale.
// RULE8: clamp duty threshold in bits 12..5, same over-255 percent scale.
// RULE9: breakpoint A upper five bits in 4..0, lower three in 30..28 of next register.
// RULE10: breakpoint B in bits 27..20 of the second profile register.
// RULE11: breakpoint C in bits 19..12 of the second profile register.
// RULE12: breakpoint D in bits 11..4 of the second profile register.
// RULE13: breakpoint E upper four bits in bits 3..0, reset to zero.
// RULE14: breakpoint E lower four bits come from bits 30..27 of following register.
// RULE15: proportional gain upper three bits come from bits 2..0 of preceding register.
// RULE16: split fields join only for control use; each register half stays read-writable.
// RULE17: reserved bit 31 reads zero and does nothing.
package slp_pkg;
    // -------------------------------------------------------------------
    // register offsets (index form, byte address is four times index)
    // -------------------------------------------------------------------
    localparam logic [7:0] SLP_IDX_GAIN = 8'h8E;
    localparam logic [7:0] SLP_IDX_PROF1 = 8'h94;
    localparam logic [7:0] SLP_IDX_PROF2 = 8'h96;
    localparam int SLP_AW = 10;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int SLP_KP_LO_MSB = 30;
    localparam int SLP_KP_LO_LSB = 24;
    localparam int SLP_KI_MSB = 23;
    localparam int SLP_KI_LSB = 14;
    localparam int SLP_MAXSPD_MSB = 13;
    localparam int SLP_PROF_MSB = 30;
    localparam int SLP_PROF_LSB = 29;
    localparam int SLP_ON_MSB = 28;
    localparam int SLP_ON_LSB = 21;
    localparam int SLP_OFF_MSB = 20;
    localparam int SLP_OFF_LSB = 13;
    localparam int SLP_CLAMP_MSB = 12;
    localparam int SLP_CLAMP_LSB = 5;
    localparam int SLP_A_HI_MSB = 4;
    localparam int SLP_A_LO_MSB = 30;
    localparam int SLP_A_LO_LSB = 28;
    localparam int SLP_B_LSB = 20;
    localparam int SLP_C_LSB = 12;
    localparam int SLP_D_LSB = 4;
    localparam int SLP_E_HI_MSB = 3;
    // -------------------------------------------------------------------
    // reset values: undefined fields come up as zero here
    // -------------------------------------------------------------------
    localparam logic [30:0] SLP_RST_GAIN = 31'h0000_0000;
    localparam logic [30:0] SLP_RST_PROF1 = 31'h0000_0000;
    localparam logic [30:0] SLP_RST_PROF2 = 31'h0000_0000;
    localparam logic [31:0] SLP_UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        SLP_PROF_SPEED_REF = 2'b00,
        SLP_PROF_LINEAR = 2'b01,
        SLP_PROF_STAIR = 2'b10,
        SLP_PROF_FWD_REV = 2'b11
    } slp_profile_e;
endpackage

// file: src/slp_duty_split.sv
/*
 * joins an eight-bit duty breakpoint from an upper and lower part of any split
 * assumes parts are registered values on the same clock
 */
`timescale 1ns/1ps
module slp_duty_split #(
    parameter int HI_W = 5
) (
    input wire logic [HI_W-1:0] i_hi,
    input wire logic [7-HI_W:0] i_lo,
    output logic [7:0] o_duty
);
    // value joined only for the control path
    assign o_duty = {i_hi, i_lo}; // RULE16
endmodule

// file: src/slp_gain_split.sv
/*
 * joins the ten-bit proportional gain code from its two register halves
 * assumes both halves are registered values on the same clock
 */
`timescale 1ns/1ps
module slp_gain_split
    import slp_pkg::*;
(
    input wire logic [2:0] i_hi,
    input wire logic [6:0] i_lo,
    output logic [9:0] o_code
);
    // concatenation only; halves stay stored separately
    assign o_code = {i_hi, i_lo}; // RULE15
endmodule

// file: src/slp_regs.sv
/*
 * speed-loop gain, maximum speed and speed-profile duty register slice
 * assumes an avalon-mm master on i_mclk; neighbour register halves arrive as ports
 */
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module slp_regs
    import slp_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [SLP_AW-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic [2:0] i_kp_hi_bits,
    input wire logic [3:0] i_duty_e_lo_bits,
    output logic [9:0] o_velocity_prop_gain_code,
    output logic [9:0] o_velocity_integral_gain_code,
    output logic [13:0] o_max_speed,
    output slp_pkg::slp_profile_e o_profile,
    output logic [7:0] o_turn_on_threshold_first,
    output logic [7:0] o_turn_off_threshold_first,
    output logic [7:0] o_clamp_threshold_first,
    output logic [7:0] o_duty_a,
    output logic [7:0] o_duty_b,
    output logic [7:0] o_duty_c,
    output logic [7:0] o_duty_d,
    output logic [7:0] o_duty_e,
    output logic [2:0] o_kp_hi_bits,
    output logic [3:0] o_duty_e_lo_bits
);
    import slp_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [30:0] gain;
        logic [30:0] prof1;
        logic [30:0] prof2;
        logic [31:0] rdata;
        logic ack;
        logic [2:0] kp_hi;
        logic [3:0] e_lo;
    } slp_state_s;

    slp_state_s st_r;
    slp_state_s st_nxt;
    logic [7:0] idx;
    logic req;

    // byte-lane merge, shared by every register write
    function automatic logic [30:0] merge(input logic [30:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = {1'b0, old};
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res[30:0]; // RULE17
    endfunction

    assign idx = i_address[SLP_AW-1:2];
    assign req = i_read | i_write;
    // one wait cycle per access, answer in the same cycle as acceptance
    assign o_waitrequest = req & ~st_r.ack;

    // -------------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = req & ~st_r.ack;
        // neighbour halves are latched for control use only
        st_nxt.kp_hi = i_kp_hi_bits; // RULE15
        st_nxt.e_lo = i_duty_e_lo_bits; // RULE14
        if (req & ~st_r.ack)
        begin
            if (i_write)
            begin
                unique case (idx)
                    SLP_IDX_GAIN: st_nxt.gain = merge(st_r.gain, i_writedata, i_byteenable); // RULE1
                    SLP_IDX_PROF1: st_nxt.prof1 = merge(st_r.prof1, i_writedata, i_byteenable); // RULE5
                    SLP_IDX_PROF2: st_nxt.prof2 = merge(st_r.prof2, i_writedata, i_byteenable); // RULE13
                    default: ;
                endcase
            end
            // bit 31 always reads zero; unmapped reads return zero
            unique case (idx)
                SLP_IDX_GAIN: st_nxt.rdata = {1'b0, st_r.gain}; // RULE17
                SLP_IDX_PROF1: st_nxt.rdata = {1'b0, st_r.prof1};
                SLP_IDX_PROF2: st_nxt.rdata = {1'b0, st_r.prof2};
                default: st_nxt.rdata = SLP_UNMAPPED;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r.gain <= SLP_RST_GAIN;
            st_r.prof1 <= SLP_RST_PROF1; // RULE5
            st_r.prof2 <= SLP_RST_PROF2; // RULE13
            st_r.rdata <= 32'h0000_0000;
            st_r.ack <= 1'b0;
            st_r.kp_hi <= 3'h0;
            st_r.e_lo <= 4'h0;
        end
        else
            st_r <= st_nxt;
    end

    assign o_readdata = st_r.rdata;

    // -------------------------------------------------------------------
    // field outputs to the control logic
    // -------------------------------------------------------------------
    // gain scaling (0.01 and 0.1 times low byte over ten to the top two bits) is applied by the consumer
    slp_gain_split u_kp (
        .i_hi(st_r.kp_hi),
        .i_lo(st_r.gain[SLP_KP_LO_MSB:SLP_KP_LO_LSB]),
        .o_code(o_velocity_prop_gain_code)
    ); // RULE2
    assign o_velocity_integral_gain_code = st_r.gain[SLP_KI_MSB:SLP_KI_LSB]; // RULE3
    assign o_max_speed = st_r.gain[SLP_MAXSPD_MSB:0]; // RULE4
    assign o_profile = slp_profile_e'(st_r.prof1[SLP_PROF_MSB:SLP_PROF_LSB]); // RULE5
    assign o_turn_on_threshold_first = st_r.prof1[SLP_ON_MSB:SLP_ON_LSB]; // RULE6
    assign o_turn_off_threshold_first = st_r.prof1[SLP_OFF_MSB:SLP_OFF_LSB]; // RULE7
    assign o_clamp_threshold_first = st_r.prof1[SLP_CLAMP_MSB:SLP_CLAMP_LSB]; // RULE8
    slp_duty_split #(.HI_W(5)) u_da (
        .i_hi(st_r.prof1[SLP_A_HI_MSB:0]),
        .i_lo(st_r.prof2[SLP_A_LO_MSB:SLP_A_LO_LSB]),
        .o_duty(o_duty_a)
    ); // RULE9
    assign o_duty_b = st_r.prof2[SLP_B_LSB +: 8]; // RULE10
    assign o_duty_c = st_r.prof2[SLP_C_LSB +: 8]; // RULE11
    assign o_duty_d = st_r.prof2[SLP_D_LSB +: 8]; // RULE12
    slp_duty_split #(.HI_W(4)) u_de (
        .i_hi(st_r.prof2[SLP_E_HI_MSB:0]),
        .i_lo(st_r.e_lo),
        .o_duty(o_duty_e)
    ); // RULE14
    // neighbour registers own these bits; echoed so they stay visible
    assign o_kp_hi_bits = st_r.kp_hi;
    assign o_duty_e_lo_bits = st_r.e_lo;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    property p_wait_one;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (req && !st_r.ack) |=> !o_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");

    property p_bit31;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (req && !o_waitrequest) |-> !o_readdata[31];
    endproperty
    a_bit31: assert property (p_bit31) else $error("bit 31 read as one"); // RULE17

    property p_kp_write;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_write && !st_r.ack && idx == SLP_IDX_GAIN && i_byteenable[3])
        |=> o_velocity_prop_gain_code[6:0] == $past(i_writedata[30:24]);
    endproperty
    a_kp_write: assert property (p_kp_write) else $error("kp low bits not stored"); // RULE1

    property p_ki_write;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_write && !st_r.ack && idx == SLP_IDX_GAIN && (&i_byteenable))
        |=> o_velocity_integral_gain_code == $past(i_writedata[23:14])
            && o_max_speed == $past(i_writedata[13:0]);
    endproperty
    a_ki_write: assert property (p_ki_write) else $error("ki or max speed wrong"); // RULE3

    property p_prof_write;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_write && !st_r.ack && idx == SLP_IDX_PROF1 && (&i_byteenable))
        |=> o_profile == $past(i_writedata[30:29]) && o_turn_on_threshold_first == $past(i_writedata[28:21])
            && o_clamp_threshold_first == $past(i_writedata[12:5]);
    endproperty
    a_prof_write: assert property (p_prof_write) else $error("profile fields wrong"); // RULE5

    // low part of breakpoint A follows a write of the second profile register
    property p_duty_a;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_write && !st_r.ack && idx == SLP_IDX_PROF2 && i_byteenable[3])
        |=> o_duty_a[2:0] == $past(i_writedata[30:28]);
    endproperty
    a_duty_a: assert property (p_duty_a) else $error("duty A join wrong"); // RULE9

    property p_duty_bcd;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_write && !st_r.ack && idx == SLP_IDX_PROF2 && (&i_byteenable))
        |=> o_duty_b == $past(i_writedata[27:20]) && o_duty_c == $past(i_writedata[19:12])
            && o_duty_d == $past(i_writedata[11:4]);
    endproperty
    a_duty_bcd: assert property (p_duty_bcd) else $error("duty B C D wrong"); // RULE10

    // the latch is still in reset on the edge that releases it, so skip that one
    property p_duty_e;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_duty_e[3:0] == $past(i_duty_e_lo_bits);
    endproperty
    a_duty_e: assert property (p_duty_e) else $error("duty E low bits wrong"); // RULE14

    property p_kp_hi;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_velocity_prop_gain_code[9:7] == $past(i_kp_hi_bits);
    endproperty
    a_kp_hi: assert property (p_kp_hi) else $error("kp high bits wrong"); // RULE15

    c_gain_write: cover property (@(posedge i_mclk) i_write && !o_waitrequest && idx == SLP_IDX_GAIN);
    c_prof2_read: cover property (@(posedge i_mclk) i_read && !o_waitrequest && idx == SLP_IDX_PROF2);
    c_stair: cover property (@(posedge i_mclk) o_profile == SLP_PROF_STAIR);
    c_prof1_write: cover property (@(posedge i_mclk) i_write && !o_waitrequest && idx == SLP_IDX_PROF1);
    c_unmapped_read: cover property (@(posedge i_mclk) i_read && !o_waitrequest && idx == 8'hFF);
endmodule

// file: tb/test_speed_loop_profile_regs.sv
/*
 * self-checking bench for the speed-loop gain and speed-profile register slice
 * assumes the slave answers through waitrequest; the bench drives neighbour bits itself
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_speed_loop_profile_regs;
    import slp_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [SLP_AW-1:0] i_address = '0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = '0;
    logic [3:0] i_byteenable = '0;
    logic [2:0] i_kp_hi_bits = '0;
    logic [3:0] i_duty_e_lo_bits = '0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [9:0] o_kp, o_ki;
    logic [13:0] o_max;
    slp_profile_e o_profile;
    logic [7:0] o_on, o_off, o_clamp, o_da, o_db, o_dc, o_dd, o_de;
    logic [2:0] o_kh;
    logic [3:0] o_el;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] m [4];
    logic [31:0] expq [$];
    logic [31:0] exp_v;
    logic [9:0] adr [4];
    slp_regs dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_kp_hi_bits(i_kp_hi_bits),
        .i_duty_e_lo_bits(i_duty_e_lo_bits), .o_velocity_prop_gain_code(o_kp),
        .o_velocity_integral_gain_code(o_ki), .o_max_speed(o_max), .o_profile(o_profile),
        .o_turn_on_threshold_first(o_on), .o_turn_off_threshold_first(o_off),
        .o_clamp_threshold_first(o_clamp), .o_duty_a(o_da), .o_duty_b(o_db), .o_duty_c(o_dc),
        .o_duty_d(o_dd), .o_duty_e(o_de), .o_kp_hi_bits(o_kh), .o_duty_e_lo_bits(o_el));
    // 50 mhz clock
    always #10 i_mclk = ~i_mclk;
    // --------------------------------------------------------------
    // read monitor: oldest note against data at the accepting edge
    // --------------------------------------------------------------
    always @(posedge i_mclk)
    begin
        if (i_read === 1'b1 && o_waitrequest === 1'b0 && expq.size() > 0)
        begin
            // pop once; the macro evaluates its expected argument twice
            exp_v = expq.pop_front();
            `CHK("readdata", exp_v, o_readdata)
        end
    end
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // request stays up after acceptance so accesses can run back to back
    task automatic acc(input logic rd, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [31:0] e);
        bit done;
        done = 0;
        if (rd)
            expq.push_back(e);
        i_read <= rd;
        i_write <= ~rd;
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        for (int n = 0; n < 20 && !done; n++)
        begin
            @(posedge i_mclk);
            if (o_waitrequest === 1'b0)
                done = 1;
        end
        if (!done)
        begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic idle();
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic wr(input int r, input logic [31:0] d, input logic [3:0] be);
        if (r < 3)
            for (int i = 0; i < 4; i++)
                if (be[i])
                    m[r][i*8+:8] = d[i*8+:8];
        acc(1'b0, adr[r], d, be, '0);
    endtask
    task automatic rd(input int r);
        acc(1'b1, adr[r], '0, 4'hF, (r < 3) ? (m[r] & 32'h7FFF_FFFF) : SLP_UNMAPPED);
    endtask
    // field outputs against the model; kh and el are the latched neighbour bits
    task automatic chk_fields(input logic [2:0] kh, input logic [3:0] el);
        `CHK("kp", {kh, m[0][30:24]}, o_kp)
        `CHK("ki", m[0][23:14], o_ki)
        `CHK("max", m[0][13:0], o_max)
        `CHK("profile", m[1][30:29], o_profile)
        `CHK("on", m[1][28:21], o_on)
        `CHK("off", m[1][20:13], o_off)
        `CHK("clamp", m[1][12:5], o_clamp)
        `CHK("duty_a", {m[1][4:0], m[2][30:28]}, o_da)
        `CHK("duty_b", m[2][27:20], o_db)
        `CHK("duty_c", m[2][19:12], o_dc)
        `CHK("duty_d", m[2][11:4], o_dd)
        `CHK("duty_e", {m[2][3:0], el}, o_de)
        `CHK("kh", kh, o_kh)
        `CHK("el", el, o_el)
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        logic [2:0] kh;
        logic [3:0] el;
        adr = '{{SLP_IDX_GAIN, 2'b00}, {SLP_IDX_PROF1, 2'b00}, {SLP_IDX_PROF2, 2'b00}, 10'h3FC};
        m = '{default: '0};
        void'($urandom(83148));
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        for (int r = 0; r < 3; r++)
            rd(r);
        idle();
        chk_fields(3'h0, 4'h0);
        $display("reset values done");
        // random contents, back-to-back writes then reads
        repeat (4)
        begin
            kh = 3'($urandom);
            el = 4'($urandom);
            i_kp_hi_bits <= kh;
            i_duty_e_lo_bits <= el;
            for (int r = 0; r < 3; r++)
                wr(r, $urandom, 4'hF);
            for (int r = 0; r < 3; r++)
                rd(r);
            idle();
            chk_fields(kh, el);
        end
        $display("random contents done");
        // every profile shape, reserved bit set on the way in
        for (int p = 0; p < 4; p++)
        begin
            wr(1, {1'b1, 2'(p), 29'($urandom)}, 4'hF);
            rd(1);
            idle();
            `CHK("profile", slp_profile_e'(p), o_profile)
        end
        $display("profile shapes done");
        // partial byte lanes keep the other bytes
        wr(0, $urandom, 4'b0101);
        wr(2, $urandom, 4'b1010);
        rd(0);
        rd(2);
        idle();
        chk_fields(kh, el);
        $display("byte lanes done");
        // unmapped place is ignored and reads zero
        wr(3, $urandom, 4'hF);
        rd(3);
        rd(0);
        idle();
        chk_fields(kh, el);
        $display("unmapped access done");
        // second reset in mid-run clears everything
        i_rst_b <= 1'b0;
        @(posedge i_mclk);
        m = '{default: '0};
        chk_fields(3'h0, 4'h0);
        i_rst_b <= 1'b1;
        rd(2);
        idle();
        $display("mid-run reset done");
        stop_test();
    end
endmodule
